// ===== spc_pkg.sv
// Shared constants and types for the serial port clock edge select block
package spc_pkg;

  // Width of one conversion code on the serial output
  localparam int SPC_CODE_W = 10;
  // Width of the command word captured from the serial input
  localparam int SPC_CMD_W = 4;
  // Width of the digitised input level presented on the system side
  localparam int SPC_LEVEL_W = 12;
  // Depth of the code FIFO ahead of the serial output
  localparam int SPC_FIFO_DEPTH = 4;
  // Stages in each synchroniser
  localparam int SPC_SYNC_STAGES = 2;

  // Mode flag values latched from frame start at chip select fall
  localparam logic SPC_MODE_HOST = 1'h1;
  localparam logic SPC_MODE_DSP = 1'h0;
  // Reset values of the link-side latches
  localparam logic SPC_MODE_RST = 1'h0;
  localparam logic SPC_INV_RST = 1'h1;
  // Saturated codes
  localparam logic [SPC_CODE_W-1:0] SPC_CODE_FULL = 10'h3FF;
  localparam logic [SPC_CODE_W-1:0] SPC_CODE_ZERO = 10'h000;

  // Active edges chosen for one frame
  typedef struct packed {
    logic captureRise;
    logic launchRise;
  } spc_edges_type;

  // Command word handed to the system side
  typedef struct packed {
    logic valid;
    logic [SPC_CMD_W-1:0] data;
  } spc_cmd_type;

endpackage

// ===== spc_sync.sv
// Multi-bit two flip-flop level synchroniser into the system clock
`timescale 1ns/1ps
module spc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  import spc_pkg::*;

  logic [WIDTH-1:0] stage1_q; // First stage, read only by the second
  logic [WIDTH-1:0] stage2_q; // Second stage, safe to use

  // Two flops per bit; each bit is an independent level or toggle
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_q <= '0;
      stage2_q <= '0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule

// ===== spc_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module spc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  import spc_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH]; // Storage entries
  logic [AW-1:0] wrPtr_q; // Next slot to write
  logic [AW-1:0] rdPtr_q; // Oldest entry
  logic [AW:0] count_q; // Entries held
  logic doWrite;
  logic doRead;

  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  assign outData = mem_q[rdPtr_q];

  // Entry storage, written at the write pointer
  always_ff @(posedge clk_sys)
  begin
    if (doWrite)
    begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers wrap at DEPTH, so DEPTH need not be a power of two
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRead)
      begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  // Occupancy count
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q <= '0;
    end
    else if (doWrite && !doRead)
    begin
      count_q <= count_q + 1'b1;
    end
    else if (doRead && !doWrite)
    begin
      count_q <= count_q - 1'b1;
    end
  end

endmodule

// ===== spc_serial_port.sv
// Serial port with mode latch, shift clock edge selection and code output
`timescale 1ns/1ps
module spc_serial_port #(
  parameter int CODE_W = spc_pkg::SPC_CODE_W,
  parameter int CMD_W = spc_pkg::SPC_CMD_W,
  parameter int LEVEL_W = spc_pkg::SPC_LEVEL_W,
  parameter int FIFO_DEPTH = spc_pkg::SPC_FIFO_DEPTH
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins; data bits timed by the host shift clock, mode and invert pins caught at select fall
  input wire logic ioClk,
  input wire logic chipSelN,
  input wire logic frame_start_strobe,
  input wire logic clock_invert_select_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  // Digitised input level and references from the converter
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [LEVEL_W-1:0] sampleLevel,
  input wire logic [LEVEL_W-1:0] refUpper,
  input wire logic [LEVEL_W-1:0] refLower,
  // Command word received from the host
  output spc_pkg::spc_cmd_type cmdOut,
  // Status seen on the system clock
  output logic host_cpu_mode,
  output logic codePending
);
  import spc_pkg::*;

  // ---------------- Link domain: frame latch ----------------
  logic hostMode_q; // Interface mode caught at select fall
  logic invHigh_q; // Invert pin level caught at select fall
  spc_edges_type edges; // Active edges for the current frame

  // The mode and the invert level are clocked by the falling select edge
  // itself, so frame start changes during the frame are never seen.
  always_ff @(negedge chipSelN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hostMode_q <= SPC_MODE_RST;
      invHigh_q <= SPC_INV_RST;
    end
    else
    begin
      hostMode_q <= frame_start_strobe ? SPC_MODE_HOST : SPC_MODE_DSP;
      invHigh_q <= clock_invert_select_n;
    end
  end

  // Capture on the rising edge when host mode and invert-high agree;
  // a grounded invert pin flips the capture edge in either mode.
  always_comb
  begin
    edges.captureRise = (hostMode_q == invHigh_q);
    edges.launchRise = (hostMode_q == SPC_MODE_DSP);
  end

  // ---------------- Link domain: input capture ----------------
  // One shifter per edge: the two edges are the same clock but separate
  // flops, so no signal is written on both edges.
  logic [CMD_W-1:0] riseShift_q; // Bits taken on rising edges
  logic [CMD_W-1:0] fallShift_q; // Bits taken on falling edges
  logic [CMD_W:0] riseInCnt_q; // Rising capture count in this frame
  logic [CMD_W:0] fallInCnt_q; // Falling capture count in this frame
  logic [CMD_W-1:0] riseCmd_q; // Completed word from rising capture
  logic [CMD_W-1:0] fallCmd_q; // Completed word from falling capture
  logic riseCmdTog_q; // Flips once per rising-captured word
  logic fallCmdTog_q; // Flips once per falling-captured word
  logic riseInLast;
  logic fallInLast;

  assign riseInLast = edges.captureRise && (riseInCnt_q == (CMD_W+1)'(CMD_W-1));
  assign fallInLast = !edges.captureRise && (fallInCnt_q == (CMD_W+1)'(CMD_W-1));

  // Rising-edge capture; select high clears the frame count
  always_ff @(posedge ioClk or posedge chipSelN)
  begin
    if (chipSelN)
    begin
      riseShift_q <= '0;
      riseInCnt_q <= '0;
    end
    else if (edges.captureRise && riseInCnt_q != (CMD_W+1)'(CMD_W))
    begin
      riseShift_q <= {riseShift_q[CMD_W-2:0], serialIn};
      riseInCnt_q <= riseInCnt_q + 1'b1;
    end
  end

  // Falling-edge capture, used when host mode and invert-high differ
  always_ff @(negedge ioClk or posedge chipSelN)
  begin
    if (chipSelN)
    begin
      fallShift_q <= '0;
      fallInCnt_q <= '0;
    end
    else if (!edges.captureRise && fallInCnt_q != (CMD_W+1)'(CMD_W))
    begin
      fallShift_q <= {fallShift_q[CMD_W-2:0], serialIn};
      fallInCnt_q <= fallInCnt_q + 1'b1;
    end
  end

  // Word hand-off from rising capture; survives select high
  always_ff @(posedge ioClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      riseCmd_q <= '0;
      riseCmdTog_q <= 1'h0;
    end
    else if (riseInLast)
    begin
      riseCmd_q <= {riseShift_q[CMD_W-2:0], serialIn};
      riseCmdTog_q <= !riseCmdTog_q;
    end
  end

  // Word hand-off from falling capture
  always_ff @(negedge ioClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fallCmd_q <= '0;
      fallCmdTog_q <= 1'h0;
    end
    else if (fallInLast)
    begin
      fallCmd_q <= {fallShift_q[CMD_W-2:0], serialIn};
      fallCmdTog_q <= !fallCmdTog_q;
    end
  end

  // ---------------- Link domain: output launch ----------------
  logic [CODE_W-1:0] txWord_q; // Code being sent; system side, held steady
  logic [$clog2(CODE_W+1)-1:0] riseOutIdx_q; // Bits launched on rising edges
  logic [$clog2(CODE_W+1)-1:0] fallOutIdx_q; // Bits launched on falling edges
  logic [$clog2(CODE_W+1)-1:0] outIdx;
  logic riseTxTog_q; // Flips when a whole code left on rising edges
  logic fallTxTog_q; // Flips when a whole code left on falling edges
  localparam logic [$clog2(CODE_W+1)-1:0] OUT_END = ($clog2(CODE_W+1))'(CODE_W);

  // Rising-edge launch, used in DSP mode
  always_ff @(posedge ioClk or posedge chipSelN)
  begin
    if (chipSelN)
    begin
      riseOutIdx_q <= '0;
    end
    else if (edges.launchRise && riseOutIdx_q != OUT_END)
    begin
      riseOutIdx_q <= riseOutIdx_q + 1'b1;
    end
  end

  // Falling-edge launch, used in host mode
  always_ff @(negedge ioClk or posedge chipSelN)
  begin
    if (chipSelN)
    begin
      fallOutIdx_q <= '0;
    end
    else if (!edges.launchRise && fallOutIdx_q != OUT_END)
    begin
      fallOutIdx_q <= fallOutIdx_q + 1'b1;
    end
  end

  // Completion toggles fire on the edge after the last bit, so the
  // system side never swaps the word while its final bit is on the pin.
  always_ff @(posedge ioClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      riseTxTog_q <= 1'h0;
    end
    else if (edges.launchRise && riseOutIdx_q == OUT_END - 1'b1 && !chipSelN)
    begin
      riseTxTog_q <= !riseTxTog_q;
    end
  end

  always_ff @(negedge ioClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fallTxTog_q <= 1'h0;
    end
    else if (!edges.launchRise && fallOutIdx_q == OUT_END - 1'b1 && !chipSelN)
    begin
      fallTxTog_q <= !fallTxTog_q;
    end
  end

  // MSB is on the pin from select fall; later bits follow the launch edge.
  // With inverted capture both counters live on the same edge as capture.
  assign outIdx = edges.launchRise ? riseOutIdx_q : fallOutIdx_q;
  assign serialOut = (outIdx < OUT_END) ? txWord_q[CODE_W-1-int'(outIdx)] : 1'h0;
  // Driver follows select directly so the pin floats as soon as select rises
  assign serialOutEn = !chipSelN;
  // The host may sample one half period later when capture is inverted;
  // nothing in the device needs to wait for that margin.

  // ---------------- Crossing into the system clock ----------------
  logic [5:0] syncOut; // Synchronised toggles and levels
  logic riseCmdTogS;
  logic fallCmdTogS;
  logic riseTxTogS;
  logic fallTxTogS;
  logic selHighS;
  logic modeS;

  // Toggles are events; select and mode are plain levels
  spc_sync #(
    .WIDTH(6)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .asyncIn({riseCmdTog_q, fallCmdTog_q, riseTxTog_q, fallTxTog_q, chipSelN, hostMode_q}),
    .syncOut(syncOut)
  );
  assign {riseCmdTogS, fallCmdTogS, riseTxTogS, fallTxTogS, selHighS, modeS} = syncOut;

  // ---------------- System domain: saturating code ----------------
  logic [CODE_W-1:0] satCode;
  logic [LEVEL_W-1:0] levelDiff;

  // Above the upper reference is full scale, below the lower is zero;
  // in range the offset from the lower reference is taken at top bits.
  always_comb
  begin
    levelDiff = sampleLevel - refLower;
    if (sampleLevel > refUpper)
    begin
      satCode = SPC_CODE_FULL;
    end
    else if (sampleLevel < refLower)
    begin
      satCode = SPC_CODE_ZERO;
    end
    else
    begin
      satCode = levelDiff[LEVEL_W-1 -: CODE_W];
    end
  end

  // ---------------- System domain: code buffering ----------------
  logic fifoValid;
  logic fifoReady;
  logic [CODE_W-1:0] fifoData;
  logic txFull_q; // A code is loaded and not yet sent
  logic riseTxSeen_q; // Last handled rising completion toggle
  logic fallTxSeen_q; // Last handled falling completion toggle
  logic txDone;

  spc_fifo #(
    .WIDTH(CODE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(satCode),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  // A new code is only loaded between frames; this stalls the FIFO
  // until the host has clocked out the previous code.
  assign txDone = (riseTxTogS != riseTxSeen_q) || (fallTxTogS != fallTxSeen_q);
  assign fifoReady = !txFull_q && selHighS;

  // Load and release of the transmit word
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txWord_q <= '0;
      txFull_q <= 1'h0;
    end
    else if (fifoValid && fifoReady)
    begin
      txWord_q <= fifoData;
      txFull_q <= 1'h1;
    end
    else if (txDone)
    begin
      txFull_q <= 1'h0;
    end
  end

  // Completion toggles already acted on
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      riseTxSeen_q <= 1'h0;
      fallTxSeen_q <= 1'h0;
    end
    else
    begin
      riseTxSeen_q <= riseTxTogS;
      fallTxSeen_q <= fallTxTogS;
    end
  end

  // ---------------- System domain: command delivery ----------------
  logic riseCmdSeen_q;
  logic fallCmdSeen_q;
  spc_cmd_type cmd_q;

  // The captured word is stable long before its toggle arrives here
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      riseCmdSeen_q <= 1'h0;
      fallCmdSeen_q <= 1'h0;
      cmd_q <= '0;
    end
    else
    begin
      riseCmdSeen_q <= riseCmdTogS;
      fallCmdSeen_q <= fallCmdTogS;
      cmd_q.valid <= (riseCmdTogS != riseCmdSeen_q) || (fallCmdTogS != fallCmdSeen_q);
      if (riseCmdTogS != riseCmdSeen_q)
      begin
        cmd_q.data <= riseCmd_q;
      end
      else if (fallCmdTogS != fallCmdSeen_q)
      begin
        cmd_q.data <= fallCmd_q;
      end
    end
  end

  // In DSP mode a frame begins only when the host lowers both select and
  // frame start; the latch above relies on that ordering.
  assign cmdOut = cmd_q;
  assign host_cpu_mode = modeS;
  assign codePending = txFull_q;

endmodule

// ===== spc_serial_port_chk.sv
// Port checker for the serial port block
`timescale 1ns/1ps
module spc_serial_port_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link and status ports
  input wire logic chipSelN,
  input wire logic frame_start_strobe,
  input wire logic serialOutEn,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire spc_pkg::spc_cmd_type cmdOut,
  input wire logic host_cpu_mode,
  input wire logic codePending
);
  import spc_pkg::*;
  logic [3:0] lowCnt_q; // Cycles select seen low, saturating
  logic [3:0] highCnt_q; // Cycles select seen high, saturating
  logic fsFall_q; // Frame start level when select fell
  logic pend_q; // Pending flag one cycle back
  logic [2:0] fill_q; // Words believed held in the buffer
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Select run lengths, mode sample and buffer fill; pops show as pending rises
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lowCnt_q <= 4'h0;
      highCnt_q <= 4'h0;
      fsFall_q <= 1'h0;
      pend_q <= 1'h0;
      fill_q <= 3'h0;
    end
    else
    begin
      lowCnt_q <= chipSelN ? 4'h0 : lowCnt_q + {3'h0, lowCnt_q != 4'hF};
      highCnt_q <= !chipSelN ? 4'h0 : highCnt_q + {3'h0, highCnt_q != 4'hF};
      if (!chipSelN && lowCnt_q == 4'h0)
        fsFall_q <= frame_start_strobe;
      pend_q <= codePending;
      fill_q <= fill_q + {2'h0, sampleValid && sampleReady} - {2'h0, codePending && !pend_q};
    end
  end

  a_en_tracks_select: assert property (serialOutEn == !chipSelN)
    else $error("output enable does not follow select");
  a_cmd_one_pulse: assert property (cmdOut.valid |=> !cmdOut.valid)
    else $error("command valid longer than one cycle");
  a_cmd_data_hold: assert property (!cmdOut.valid |-> $stable(cmdOut.data))
    else $error("command data moved without valid");
  a_mode_from_fs: assert property (lowCnt_q == 4'h7 |-> host_cpu_mode == fsFall_q)
    else $error("mode flag differs from frame start at select fall");
  a_mode_frozen: assert property (lowCnt_q >= 4'h6 |-> $stable(host_cpu_mode))
    else $error("mode flag moved inside a frame");
  a_buf_refuse: assert property (codePending && pend_q |-> sampleReady == (fill_q != 3'h4))
    else $error("buffer ready does not match its fill");
  a_pend_idle_hold: assert property (highCnt_q >= 4'h6 && codePending |=> codePending)
    else $error("pending code lost while idle");
  a_reset_quiet: assert property ($rose(rst_n) |-> !host_cpu_mode && !codePending && sampleReady)
    else $error("status not at reset values");
  c_cmd: cover property (cmdOut.valid);
  c_full: cover property (!sampleReady);
  c_host: cover property ($rose(host_cpu_mode));
endmodule

// ===== spc_host_model.sv
// Host serial port model for the link pins
`timescale 1ns/1ps
module spc_host_model (
  // Link pins driven by the host
  output logic ioClk,
  output logic chipSelN,
  output logic frame_start_strobe,
  output logic clock_invert_select_n,
  output logic serialIn,
  // Code bits coming back
  input wire logic serialOut
);
  // Idle: clock parked low, select and frame start high
  initial
  begin
    ioClk = 1'h0;
    frame_start_strobe = 1'h1;
    clock_invert_select_n = 1'h1;
    serialIn = 1'h0;
    // Select rises after time zero so the frame counters surely see their clearing edge
    #1 chipSelN = 1'h1;
  end

  // Ten shift clocks of 30 ns; wiggle flips the mode pins mid-frame
  task automatic frame(input logic mode, input logic inv, input logic [3:0] cmd, input logic wiggle,
    output logic [9:0] code);
    clock_invert_select_n = inv;
    frame_start_strobe = mode;
    #5 chipSelN = 1'h0;
    #20;
    for (int i = 0; i < 10; i++)
    begin
      // Bit set 7 ns before the rise and kept past the fall suits both capture edges
      serialIn = (i < 4) ? cmd[3 - i] : ~serialIn;
      // DSP launches on rises, so read before the rise
      if (!mode)
        code[9 - i] = serialOut;
      if (wiggle && i == 5)
      begin
        frame_start_strobe = ~mode;
        clock_invert_select_n = ~inv;
      end
      #7 ioClk = 1'h1;
      #7;
      if (mode)
        code[9 - i] = serialOut;
      #8 ioClk = 1'h0;
      #8;
    end
    // Hold select past the last fall, then idle long enough to load a code
    #60 chipSelN = 1'h1;
    serialIn = ~serialIn;
    frame_start_strobe = 1'h1;
    clock_invert_select_n = ~inv;
    #200;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ps
module tb;
  import spc_pkg::*;
  typedef struct packed {logic mode; logic inv; logic [3:0] cmd; logic [11:0] level; logic [9:0] exp;} spc_row_type;
  logic clk_sys = 1'h0;
  logic rst_n; // Set low by non-blocking at time zero so every reset branch sees a falling edge
  logic ioClk, chipSelN, frame_start_strobe, clock_invert_select_n, serialIn, serialOut, serialOutEn;
  logic sampleValid = 1'h0;
  logic sampleReady, host_cpu_mode, codePending;
  logic [11:0] sampleLevel = 12'h000;
  logic [11:0] refUpper = 12'hC00;
  logic [11:0] refLower = 12'h100;
  spc_cmd_type cmdOut;
  int error_cnt = 0;
  int checked = 0;
  int cmdCnt = 0; // Command pulses seen
  logic [3:0] lastCmd; // Data of the latest command pulse
  logic [9:0] code; // Word read by the host
  // One row per mode and clock polarity, inside and outside the references
  spc_row_type rows [4] = '{'{1'h1, 1'h1, 4'hA, 12'h500, 10'h100}, '{1'h0, 1'h1, 4'h5, 12'hD00, 10'h3FF},
    '{1'h1, 1'h0, 4'h3, 12'h0FF, 10'h000}, '{1'h0, 1'h0, 4'hC, 12'hC00, 10'h2C0}};

  always #20 clk_sys = ~clk_sys;

  spc_serial_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ioClk(ioClk), .chipSelN(chipSelN),
    .frame_start_strobe(frame_start_strobe), .clock_invert_select_n(clock_invert_select_n),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleLevel(sampleLevel), .refUpper(refUpper), .refLower(refLower),
    .cmdOut(cmdOut), .host_cpu_mode(host_cpu_mode), .codePending(codePending));
  spc_host_model u_host (.ioClk(ioClk), .chipSelN(chipSelN), .frame_start_strobe(frame_start_strobe),
    .clock_invert_select_n(clock_invert_select_n), .serialIn(serialIn), .serialOut(serialOut));

  // Record every command pulse
  always @(posedge clk_sys)
  begin
    if (cmdOut.valid === 1'h1)
    begin
      lastCmd <= cmdOut.data;
      cmdCnt <= cmdCnt + 1;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Offer one level; ready is read at the falling edge so the taking edge is known
  task automatic push(input logic [11:0] lvl);
    int n;
    @(posedge clk_sys);
    sampleValid <= 1'h1;
    sampleLevel <= lvl;
    n = 0;
    @(negedge clk_sys);
    while (sampleReady !== 1'h1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    sampleValid <= 1'h0;
    check(16'(n < 50), 16'h0001, "sample taken");
  endtask

  // Bounded wait for a loaded code
  task automatic wait_pend();
    int n;
    n = 0;
    while (codePending !== 1'h1 && n < 100)
    begin
      @(negedge clk_sys);
      n++;
    end
    check(codePending, 16'h0001, "code pending");
  endtask

  // Watchdog well beyond the expected few microseconds
  initial
  begin
    #100000;
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    rst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk_sys);
    foreach (rows[r])
    begin
      push(rows[r].level);
      wait_pend();
      u_host.frame(rows[r].mode, rows[r].inv, rows[r].cmd, 1'h0, code);
      check(code, rows[r].exp, "code");
      check(lastCmd, rows[r].cmd, "command");
      check(cmdCnt[15:0], 16'(r + 1), "command count");
      check(host_cpu_mode, rows[r].mode, "mode");
    end
    // One code pending and four buffered, so the buffer refuses further levels
    for (int k = 0; k < 5; k++)
      push(12'h100 + 12'(k * 64));
    repeat (3) @(posedge clk_sys);
    check(sampleReady, 16'h0000, "full buffer");
    // Drain with the mode pins flipped mid-frame; latched settings must hold
    for (int k = 0; k < 5; k++)
    begin
      wait_pend();
      u_host.frame(!k[0], k[1], 4'h6, 1'h1, code);
      check(code, 16'(k * 16), "drained code");
      check(lastCmd, 16'h0006, "drained command");
      check(host_cpu_mode, !k[0], "drained mode");
    end
    // Reset in mid-run clears the status outputs
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk_sys);
    check({cmdOut, host_cpu_mode, codePending, sampleReady}, 16'h0001, "reset values");
    rst_n <= 1'h1;
    repeat (4) @(posedge clk_sys);
    check({cmdOut, host_cpu_mode, codePending, sampleReady}, 16'h0001, "after reset");
    end_sim();
  end
endmodule

bind spc_serial_port spc_serial_port_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .chipSelN(chipSelN),
  .frame_start_strobe(frame_start_strobe), .serialOutEn(serialOutEn), .sampleValid(sampleValid),
  .sampleReady(sampleReady), .cmdOut(cmdOut), .host_cpu_mode(host_cpu_mode), .codePending(codePending));
